// ==== fom_pkg.sv ====
package fom_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses on the register bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DEV = 8'h04;
	localparam logic [7:0] OFS_RATE = 8'h08;
	localparam logic [7:0] OFS_SHAPE = 8'h0C;
	localparam logic [7:0] OFS_PEAK = 8'h10;
	localparam logic [7:0] OFS_CARRIER = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_BW = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TX = 0;
	localparam int CTRL_RX = 1;
	localparam int CTRL_OOK = 2;
	localparam int CTRL_PACKET = 3;
	localparam int CTRL_SYNC_OFF = 4;
	localparam int CTRL_AUTO_ON = 5;
	localparam int CTRL_AUTO_CLR = 6;
	localparam int CTRL_RX_OOK = 7;
	localparam int CTRL_ON_PREAMBLE = 8;
	localparam int RATE_FRAC_LSB = 16;
	localparam int SHAPE_STEP_LSB = 4;
	localparam int PEAK_STEP_LSB = 2;
	localparam int PEAK_PERIOD_LSB = 5;
	localparam int PEAK_FLOOR_LSB = 8;
	localparam int BW_AFC_LSB = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DEV_RST = 32'h0000_0052;
	localparam logic [31:0] RATE_RST = 32'h0000_1A0B;
	localparam logic [31:0] SHAPE_RST = 32'h0000_0000;
	localparam logic [31:0] PEAK_RST = 32'h0000_0C01;
	localparam logic [31:0] CARRIER_RST = 32'h006C_8000;
	localparam logic [31:0] BW_RST = 32'h0000_0B15;

	// ----------------------------------------------------------------
	// modes and constants
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		THR_FIXED = 2'b00,
		THR_PEAK = 2'b01,
		THR_AVG = 2'b10
	} fom_thr_t;
	localparam logic [1:0] SHAPE_NONE = 2'b00;
	localparam logic [1:0] SHAPE_BT1 = 2'b01;
	localparam logic [1:0] SHAPE_BT05 = 2'b10;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_AFC = 3'b010,
		RX_RUN = 3'b100
	} fom_rx_t;
	localparam logic [7:0] RSSI_6DB = 8'h0C;
	localparam logic [7:0] PEAK_DEC_UNIT = 8'h10;
	localparam logic [7:0] PA_MAX = 8'hFF;
	localparam logic [1:0] FEI_LAST = 2'h3;
	localparam logic [20:0] SUB_STEP = 21'h0_0010;
	localparam logic signed [5:0] LVL_FULL = 6'sd16;
	localparam logic signed [5:0] BT1_EDGE = 6'sd1;
	localparam logic signed [5:0] BT1_MID = 6'sd14;
	localparam logic signed [5:0] BT05_EDGE = 6'sd2;
	localparam logic signed [5:0] BT05_MID = 6'sd12;

	// one step of a bit timer kept in sixteenths of a clock
	function automatic logic [20:0] fom_rate_step(input logic [19:0] acc,
			input logic [19:0] per);
		logic [20:0] sum;
		sum = {1'b0, acc} + SUB_STEP;
		if (sum >= {1'b0, per}) begin
			fom_rate_step = {1'b1, sum[19:0] - per};
		end else begin
			fom_rate_step = {1'b0, sum[19:0]};
		end
	endfunction : fom_rate_step

	// byte-lane merge of a register write
	function automatic logic [31:0] fom_merge(input logic [31:0] old,
			input logic [31:0] wdata, input logic [3:0] strb);
		fom_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				fom_merge[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
	endfunction : fom_merge

	// three-bit gaussian kernel, +-16 full scale
	function automatic logic signed [5:0] fom_gauss(input logic [2:0] b,
			input logic bt05);
		logic signed [5:0] e;
		logic signed [5:0] m;
		e = bt05 ? BT05_EDGE : BT1_EDGE;
		m = bt05 ? BT05_MID : BT1_MID;
		fom_gauss = (b[2] ? e : -e) + (b[1] ? m : -m) + (b[0] ? e : -e);
	endfunction : fom_gauss
endpackage : fom_pkg

// ==== fom_ook_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface fom_ook_if;
	logic [7:0] rssi;
	logic [1:0] thr_type;
	logic [2:0] dec_step;
	logic [2:0] dec_period;
	logic [7:0] floor_threshold;
	logic [7:0] threshold;
	logic ook_bit;
	modport core (output rssi, thr_type, dec_step, dec_period,
		floor_threshold, input threshold, ook_bit);
	modport thr (input rssi, thr_type, dec_step, dec_period,
		floor_threshold, output threshold, ook_bit);
endinterface : fom_ook_if
`default_nettype wire

// ==== fom_ook_thresh.sv ====
`timescale 1ns/10ps
`default_nettype none
module fom_ook_thresh import fom_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// threshold link to the core
	fom_ook_if.thr ook
);
	logic [7:0] peak;
	logic [7:0] next_peak;
	logic [11:0] avg_acc;
	logic [11:0] next_avg_acc;
	logic [7:0] dec_cnt;
	logic [7:0] next_dec_cnt;
	logic [7:0] next_threshold;
	logic next_bit;
	logic [7:0] dec_len;
	logic [7:0] peak_thr;
	logic [7:0] step;
	logic [8:0] hold_lvl;

	// peak tracking, decay and threshold choice
	always_comb begin
		dec_len = 8'((ook.dec_period + 3'd1) * PEAK_DEC_UNIT);
		step = {5'h00, ook.dec_step} + 8'h01;
		// nine bits so a high floor cannot wrap the hold level
		hold_lvl = {1'b0, ook.floor_threshold} + {1'b0, RSSI_6DB};
		next_dec_cnt = (dec_cnt + 8'h01 >= dec_len) ? 8'h00 : dec_cnt + 8'h01;
		next_peak = peak;
		next_avg_acc = avg_acc - {4'h0, avg_acc[11:4]} + {4'h0, ook.rssi};
		if (ook.rssi > peak) begin
			next_peak = ook.rssi;
		end else if (next_dec_cnt == 8'h00 && ook.rssi <= ook.threshold) begin
			if ({1'b0, peak} >= hold_lvl + {1'b0, step}) begin
				next_peak = peak - step;
			end else begin
				next_peak = hold_lvl[8] ? 8'hFF : hold_lvl[7:0];
			end
		end
		peak_thr = ({1'b0, peak} > hold_lvl) ?
			peak - RSSI_6DB : ook.floor_threshold;
		case (ook.thr_type)
			THR_PEAK: next_threshold = peak_thr;
			THR_AVG: next_threshold = avg_acc[11:4];
			default: next_threshold = ook.floor_threshold;
		endcase
		next_bit = ook.rssi > ook.threshold;
	end

	// state registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			peak <= 8'h00;
			avg_acc <= 12'h000;
			dec_cnt <= 8'h00;
			ook.threshold <= 8'h00;
			ook.ook_bit <= 1'b0;
		end else begin
			peak <= next_peak;
			avg_acc <= next_avg_acc;
			dec_cnt <= next_dec_cnt;
			ook.threshold <= next_threshold;
			ook.ook_bit <= next_bit;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_fixed_thr;
		@(posedge ref_clk) disable iff (!reset_n)
		ook.thr_type == THR_FIXED ##1 ook.thr_type == THR_FIXED
			|-> ook.threshold == $past(ook.floor_threshold);
	endproperty
	a_fixed_thr: assert property (p_fixed_thr)
		else $error("fixed threshold differs from floor");
	property p_peak_floor;
		@(posedge ref_clk) disable iff (!reset_n)
		ook.thr_type == THR_PEAK ##1 ook.thr_type == THR_PEAK
			|-> ook.threshold >= $past(ook.floor_threshold);
	endproperty
	a_peak_floor: assert property (p_peak_floor)
		else $error("peak threshold fell below floor");
	property p_peak_6db;
		@(posedge ref_clk) disable iff (!reset_n)
		ook.thr_type == THR_PEAK &&
			{1'b0, peak} > {1'b0, ook.floor_threshold} + {1'b0, RSSI_6DB}
			|=> ook.threshold == $past(peak) - RSSI_6DB;
	endproperty
	a_peak_6db: assert property (p_peak_6db)
		else $error("peak threshold not 6 dB below peak");
endmodule : fom_ook_thresh
`default_nettype wire

// ==== fom_modem.sv ====
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - deviation equals step size times the 14-bit deviation word
// - keying mode switches the amplifier on for one bit, off for other
// - shaping field selects a gaussian filter, BT 0.5 or 1
// - continuous gaussian transmit clocks each next bit out on data clock
// - keying shaping ramps amplifier level smoothly up and down
// - frequency demodulator output can feed the bit synchronizer
// - keying receive compares signal strength against a selected threshold
// - peak mode threshold is tracked peak less 6 dB
// - held peak drops one step per decrement period on zeros
// - peak decay stops 6 dB above the programmed floor
// - fixed mode uses the floor, average mode averages strength
// - synchronizer recovers timing, drives data clock pin, can be disabled
// - packet mode forces the synchronizer on at programmed rate
// - sender and receiver bit rates differ by at most 6.5 percent
// - frequency error measured over 4 bits, refreshed every 4 bits
// - auto correction subtracts the correction, cleared or accumulated
// - correction phase uses its own bandwidth, then channel bandwidth
// - bit period is rate word plus fraction over 16 clocks, rate word alone in keying mode
module fom_modem import fom_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register bus
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor data pins
	input wire logic tx_data_pin,
	output logic rx_data_pin,
	output logic shared_data_clock_pin,
	// radio side, same clock
	input wire logic [7:0] rssi_value,
	input wire logic fsk_demod_bit,
	input wire logic signed [15:0] freq_disc_sample,
	input wire logic preamble_found_flag,
	output logic [23:0] freq_word_out,
	output logic [7:0] pa_level,
	output logic [4:0] rx_bandwidth
);
	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [31:0] ctrl, dev, rate, shape, peak_cfg, carrier, bw;
	logic [31:0] next_ctrl, next_dev, next_rate, next_shape;
	logic [31:0] next_peak_cfg, next_carrier, next_bw;
	logic [31:0] rdata;
	logic addr_ok, wr_en;
	logic signed [15:0] fei_res;
	logic signed [15:0] corr;
	fom_rx_t rx_state;

	// address decode and read mux
	always_comb begin
		addr_ok = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			OFS_CTRL: rdata = ctrl;
			OFS_DEV: rdata = dev;
			OFS_RATE: rdata = rate;
			OFS_SHAPE: rdata = shape;
			OFS_PEAK: rdata = peak_cfg;
			OFS_CARRIER: rdata = carrier;
			OFS_STATUS: rdata = {13'h0000, rx_state, fei_res};
			OFS_BW: rdata = bw;
			default: addr_ok = 1'b0;
		endcase
		wr_en = psel & penable & pwrite & addr_ok;
		pready = 1'b1;
		pslverr = psel & penable & !addr_ok;
	end

	// register writes, byte lanes honoured
	always_comb begin
		next_ctrl = ctrl;
		next_dev = dev;
		next_rate = rate;
		next_shape = shape;
		next_peak_cfg = peak_cfg;
		next_carrier = carrier;
		next_bw = bw;
		if (wr_en) begin
			case (paddr)
				OFS_CTRL: next_ctrl = fom_merge(ctrl, pwdata, pstrb) & 32'h0000_01FF;
				OFS_DEV: next_dev = fom_merge(dev, pwdata, pstrb) & 32'h0000_3FFF;
				OFS_RATE: next_rate = fom_merge(rate, pwdata, pstrb) & 32'h000F_FFFF;
				OFS_SHAPE: next_shape = fom_merge(shape, pwdata, pstrb) & 32'h0000_00F3;
				OFS_PEAK: next_peak_cfg = fom_merge(peak_cfg, pwdata, pstrb) & 32'h0000_FFFF;
				OFS_CARRIER: next_carrier = fom_merge(carrier, pwdata, pstrb) & 32'h00FF_FFFF;
				OFS_BW: next_bw = fom_merge(bw, pwdata, pstrb) & 32'h0000_1F1F;
				default: ;
			endcase
		end
	end

	// register state; read data is captured in the setup cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= CTRL_RST;
			dev <= DEV_RST;
			rate <= RATE_RST;
			shape <= SHAPE_RST;
			peak_cfg <= PEAK_RST;
			carrier <= CARRIER_RST;
			bw <= BW_RST;
			prdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			dev <= next_dev;
			rate <= next_rate;
			shape <= next_shape;
			peak_cfg <= next_peak_cfg;
			carrier <= next_carrier;
			bw <= next_bw;
			if (psel && !penable) begin
				prdata <= rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// common decode
	// ----------------------------------------------------------------
	logic tx_en, rx_en, ook_mode, bs_on, gauss_on, bt05, ook_shape;
	logic [19:0] period, half;
	logic [1:0] shaping_select;
	logic [7:0] ramp_step;
	always_comb begin
		tx_en = ctrl[CTRL_TX];
		rx_en = ctrl[CTRL_RX] & !ctrl[CTRL_TX];
		ook_mode = ctrl[CTRL_OOK];
		shaping_select = shape[1:0];
		gauss_on = !ook_mode && shaping_select != SHAPE_NONE;
		bt05 = shaping_select == SHAPE_BT05;
		ook_shape = ook_mode && shaping_select != SHAPE_NONE;
		ramp_step = {4'h0, shape[SHAPE_STEP_LSB +: 4]} + 8'h01;
		bs_on = ctrl[CTRL_PACKET] | !ctrl[CTRL_SYNC_OFF];
		period = ook_mode ? {rate[15:0], 4'h0} :
			{rate[15:0], rate[RATE_FRAC_LSB +: 4]};
		half = period >> 1;
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	logic tx_meta, tx_sync;
	logic [19:0] tx_acc, next_tx_acc;
	logic [2:0] tx_bits, next_tx_bits;
	logic tx_cap, next_tx_cap, tx_recovered_data_clock, next_tx_recovered_data_clock, tx_tick, tx_bit;
	logic [7:0] next_pa;
	logic [23:0] next_freq;
	logic signed [5:0] lvl;
	logic signed [20:0] prod;
	logic [20:0] tx_step;

	// data pin comes from the processor's clock world
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_meta <= 1'b0;
			tx_sync <= 1'b0;
		end else begin
			tx_meta <= tx_data_pin;
			tx_sync <= tx_meta;
		end
	end

	always_comb begin
		tx_step = fom_rate_step(tx_acc, period);
		tx_tick = tx_en & tx_step[20];
		next_tx_acc = tx_en ? tx_step[19:0] : 20'h0_0000;
		// data clock high for first half of each bit
		next_tx_recovered_data_clock = tx_en && gauss_on && next_tx_acc < half;
		// bit is taken at the falling data clock, mid bit
		next_tx_cap = (tx_recovered_data_clock && !next_tx_recovered_data_clock) ? tx_sync : tx_cap;
		next_tx_bits = tx_tick ? {tx_bits[1:0], tx_cap} : tx_bits;
		// without the filter the pin feeds the modulator directly
		tx_bit = gauss_on ? tx_bits[1] : tx_sync;
		// gaussian kernel ahead of the divider
		lvl = gauss_on ? fom_gauss(tx_bits, bt05) :
			(tx_bit ? LVL_FULL : -LVL_FULL);
		prod = $signed({1'b0, dev[13:0]}) * lvl;
		next_freq = carrier[23:0] - {{8{corr[15]}}, corr};
		if (tx_en && !ook_mode) begin
			next_freq = next_freq + {{7{prod[20]}}, prod[20:4]};
		end
		// amplifier on in transmit, keyed by the data bit in keying mode
		next_pa = (tx_en && (!ook_mode || tx_bit)) ? PA_MAX : 8'h00;
		// ramp the amplifier instead of stepping
		if (ook_shape && next_pa > pa_level && next_pa - pa_level > ramp_step) begin
			next_pa = pa_level + ramp_step;
		end else if (ook_shape && next_pa < pa_level &&
				pa_level - next_pa > ramp_step) begin
			next_pa = pa_level - ramp_step;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_acc <= 20'h0_0000;
			tx_bits <= 3'h0;
			tx_cap <= 1'b0;
			tx_recovered_data_clock <= 1'b0;
			pa_level <= 8'h00;
			freq_word_out <= 24'h00_0000;
		end else begin
			tx_acc <= next_tx_acc;
			tx_bits <= next_tx_bits;
			tx_cap <= next_tx_cap;
			tx_recovered_data_clock <= next_tx_recovered_data_clock;
			pa_level <= next_pa;
			freq_word_out <= next_freq;
		end
	end

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	fom_ook_if ook ();
	fom_ook_thresh u_thr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ook(ook.thr)
	);
	assign ook.rssi = rssi_value;
	assign ook.thr_type = peak_cfg[1:0];
	assign ook.dec_step = peak_cfg[PEAK_STEP_LSB +: 3];
	assign ook.dec_period = peak_cfg[PEAK_PERIOD_LSB +: 3];
	assign ook.floor_threshold = peak_cfg[PEAK_FLOOR_LSB +: 8];

	logic [19:0] rx_acc, next_rx_acc;
	logic rx_prev, rx_q, next_rx_q, rx_en_q, rx_tick, demod_bit, fei_run;
	logic [1:0] fei_cnt, next_fei_cnt;
	logic signed [17:0] fei_acc, next_fei_acc, fei_sum;
	logic signed [15:0] next_fei_res, next_corr;
	logic fei_done;
	fom_rx_t next_rx_state;
	logic [4:0] next_bw_out;
	logic next_data_pin, next_recovered_data_clock_pin;
	logic [20:0] rx_step;

	always_comb begin
		demod_bit = ctrl[CTRL_RX_OOK] ? ook.ook_bit : fsk_demod_bit;
		rx_step = fom_rate_step(rx_acc, period);
		rx_tick = rx_en & rx_step[20];
		// data edge pulls the phase to mid bit
		if (!rx_en) begin
			next_rx_acc = 20'h0_0000;
		end else if (demod_bit != rx_prev) begin
			next_rx_acc = half;
		end else begin
			next_rx_acc = rx_step[19:0];
		end
		next_rx_q = rx_tick ? demod_bit : rx_q;
		// clean output or raw stream on the pins
		next_data_pin = bs_on ? next_rx_q : demod_bit;
		next_recovered_data_clock_pin = rx_en ? (bs_on && next_rx_acc >= half) : next_tx_recovered_data_clock;
		// four bit measurement, restarted each time
		fei_run = rx_en && (!ctrl[CTRL_ON_PREAMBLE] || preamble_found_flag);
		fei_sum = fei_acc + {{2{freq_disc_sample[15]}}, freq_disc_sample};
		fei_done = fei_run && rx_tick && fei_cnt == FEI_LAST;
		next_fei_cnt = !fei_run ? 2'h0 : (rx_tick ? fei_cnt + 2'h1 : fei_cnt);
		next_fei_acc = (!fei_run || fei_done) ? 18'sh0_0000 :
			(rx_tick ? fei_sum : fei_acc);
		next_fei_res = fei_done ? fei_sum[17:2] : fei_res;
		next_corr = corr;
		next_rx_state = rx_state;
		case (rx_state)
			RX_IDLE: begin
				if (rx_en && !rx_en_q && ctrl[CTRL_AUTO_ON]) begin
					if (ctrl[CTRL_AUTO_CLR]) begin
						next_corr = 16'sh0000;
					end
					next_rx_state = RX_AFC;
				end else if (rx_en) begin
					next_rx_state = RX_RUN;
				end
			end
			RX_AFC: begin
				if (!rx_en) begin
					next_rx_state = RX_IDLE;
				end else if (fei_done) begin
					next_corr = corr + fei_sum[17:2];
					next_rx_state = RX_RUN;
				end
			end
			RX_RUN: next_rx_state = rx_en ? RX_RUN : RX_IDLE;
			default: next_rx_state = RX_IDLE;
		endcase
		// correction bandwidth only in the correction phase
		next_bw_out = (next_rx_state == RX_AFC) ? bw[BW_AFC_LSB +: 5] : bw[4:0];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_acc <= 20'h0_0000;
			rx_prev <= 1'b0;
			rx_q <= 1'b0;
			rx_en_q <= 1'b0;
			fei_cnt <= 2'h0;
			fei_acc <= 18'sh0_0000;
			fei_res <= 16'sh0000;
			corr <= 16'sh0000;
			rx_state <= RX_IDLE;
			rx_bandwidth <= 5'h00;
			rx_data_pin <= 1'b0;
			shared_data_clock_pin <= 1'b0;
		end else begin
			rx_acc <= next_rx_acc;
			rx_prev <= demod_bit;
			rx_q <= next_rx_q;
			rx_en_q <= rx_en;
			fei_cnt <= next_fei_cnt;
			fei_acc <= next_fei_acc;
			fei_res <= next_fei_res;
			corr <= next_corr;
			rx_state <= next_rx_state;
			rx_bandwidth <= next_bw_out;
			rx_data_pin <= next_data_pin;
			shared_data_clock_pin <= next_recovered_data_clock_pin;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_ook_key;
		@(posedge ref_clk) disable iff (!reset_n)
		tx_en && ook_mode && !ook_shape && tx_bit |=> pa_level == PA_MAX;
	endproperty
	a_ook_key: assert property (p_ook_key)
		else $error("amplifier not on for a one");
	property p_ramp;
		@(posedge ref_clk) disable iff (!reset_n)
		ook_shape ##1 ook_shape |-> (pa_level >= $past(pa_level) ?
			pa_level - $past(pa_level) : $past(pa_level) - pa_level)
			<= $past(ramp_step);
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("amplifier level stepped");
	property p_dev;
		@(posedge ref_clk) disable iff (!reset_n)
		tx_en && !ook_mode && !gauss_on && tx_bit |=> freq_word_out ==
			$past(carrier[23:0] - {{8{corr[15]}}, corr} + {2'b00, dev[13:0], 8'h00} / 24'h00_0100);
	endproperty
	a_dev: assert property (p_dev)
		else $error("deviation wrong");
	property p_recovered_data_clock_tick;
		@(posedge ref_clk) disable iff (!reset_n)
		!rx_en && $rose(tx_recovered_data_clock) |-> $past(tx_en && gauss_on);
	endproperty
	a_recovered_data_clock_tick: assert property (p_recovered_data_clock_tick)
		else $error("data clock without gaussian transmit");
	property p_fei_four;
		@(posedge ref_clk) disable iff (!reset_n)
		fei_done |-> fei_cnt == FEI_LAST ##1 fei_res == $past(fei_sum[17:2]);
	endproperty
	a_fei_four: assert property (p_fei_four)
		else $error("frequency error not taken after four bits");
	property p_clear;
		@(posedge ref_clk) disable iff (!reset_n)
		rx_state == RX_IDLE && rx_en && !rx_en_q && ctrl[CTRL_AUTO_ON] &&
			ctrl[CTRL_AUTO_CLR] |=> corr == 16'sh0000 && rx_state == RX_AFC;
	endproperty
	a_clear: assert property (p_clear)
		else $error("correction not cleared");
	property p_afc_bw;
		@(posedge ref_clk) disable iff (!reset_n)
		rx_state == RX_AFC && $stable(bw) |-> rx_bandwidth == bw[BW_AFC_LSB +: 5];
	endproperty
	a_afc_bw: assert property (p_afc_bw)
		else $error("correction bandwidth not applied");
	property p_raw;
		@(posedge ref_clk) disable iff (!reset_n)
		!bs_on |=> rx_data_pin == $past(demod_bit);
	endproperty
	a_raw: assert property (p_raw)
		else $error("raw stream not passed when synchronizer off");
	c_gauss: cover property (@(posedge ref_clk) disable iff (!reset_n)
		tx_tick && gauss_on);
	c_afc: cover property (@(posedge ref_clk) disable iff (!reset_n)
		rx_state == RX_AFC && fei_done);
	c_ook: cover property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(ook.ook_bit));
endmodule : fom_modem
`default_nettype wire

// ==== fom_proc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------
// processor model
// ----------------
module fom_proc_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// link pins
	input wire logic shared_data_clock_pin,
	input wire logic gen,
	input wire logic hold_bit,
	output logic tx_data_pin,
	output logic [15:0] edges
);
	logic prev;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev <= 1'b0;
			edges <= 16'h0000;
			tx_data_pin <= 1'b0;
		end else begin
			prev <= shared_data_clock_pin;
			if (!gen) begin
				tx_data_pin <= hold_bit;
			end else if (shared_data_clock_pin && !prev) begin
				edges <= edges + 16'h0001;
				tx_data_pin <= ~tx_data_pin;
			end
		end
	end
endmodule : fom_proc_model
`default_nettype wire

// ==== fom_modem_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------
// modem bench
// ------------
module fom_modem_tb import fom_pkg::*;;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, rssi = 0;
	logic [31:0] pwdata = 0, prdata, d;
	logic pready, pslverr, rx, recovered_data_clock, tx, gen = 0, hb = 0, dmd = 0, pf = 0;
	logic [23:0] fw;
	logic [7:0] pa;
	logic [4:0] bw;
	logic [15:0] edges, e0 = 0, ne, fd = 0;
	logic [2:0] probe = 0;
	logic [31:0] obs;
	logic [31:0] exp_q[$];
	int errors = 0, total_checks = 0, cyc = 0;
	always #5 ref_clk = ~ref_clk;
	assign ne = edges - e0;
	// observed value chosen by the pending probe
	assign obs = probe == 1 ? {24'h0, pa} : probe == 2 ? {31'h0, rx} :
		probe == 3 ? {31'h0, ne >= 16'd19 && ne <= 16'd21} :
		probe == 5 ? {27'h0, bw} : probe == 6 ? {8'h0, fw} :
		{31'h0, pa != 8'h00 && pa != PA_MAX};
	fom_modem u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_data_pin(tx), .rx_data_pin(rx), .shared_data_clock_pin(recovered_data_clock),
		.rssi_value(rssi), .fsk_demod_bit(dmd), .freq_disc_sample(fd),
		.preamble_found_flag(pf), .freq_word_out(fw), .pa_level(pa),
		.rx_bandwidth(bw));
	fom_proc_model u_proc (.ref_clk(ref_clk), .reset_n(reset_n),
		.shared_data_clock_pin(recovered_data_clock), .gen(gen), .hold_bit(hb),
		.tx_data_pin(tx), .edges(edges));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	// one apb transfer, held until pready
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] v);
		paddr <= a;
		pwrite <= w;
		pwdata <= v;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		apb(a, 1'b0, 32'h0000_0000);
	endtask : rd
	task automatic pk(input logic [2:0] s, input logic [31:0] want);
		exp_q.push_back(want);
		probe <= s;
		@(posedge ref_clk);
		probe <= 3'd0;
	endtask : pk
	// result watcher: pops the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		cyc++;
		if (psel && penable && !pwrite) check({pslverr, prdata[30:0]},
			exp_q.pop_front());
		else if (probe != 3'd0) check(obs, exp_q.pop_front());
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'hd7ad));
		wt(3);
		reset_n <= 1'b1;
		wt(1);
		rd(OFS_DEV, DEV_RST);
		rd(OFS_RATE, RATE_RST);
		rd(OFS_PEAK, PEAK_RST);
		rd(OFS_STATUS, 32'h0001_0000);
		rd(8'h20, 32'h8000_0000);
		d = 32'h0000_0010 + 32'($urandom % 3000);
		apb(OFS_DEV, 1'b1, d);
		rd(OFS_DEV, d);
		apb(OFS_CTRL, 1'b1, 32'h0000_0005);
		hb <= 1'b1;
		wt(8);
		pk(1, PA_MAX);
		hb <= 1'b0;
		wt(8);
		pk(1, 0);
		apb(OFS_SHAPE, 1'b1, 32'h0000_00F1);
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0005);
		hb <= 1'b1;
		wt(6);
		pk(4, 1);
		wt(40);
		pk(1, PA_MAX);
		hb <= 1'b0;
		wt(6);
		pk(4, 1);
		// plain frequency keying, carrier plus or minus deviation
		apb(OFS_SHAPE, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0001);
		hb <= 1'b1;
		wt(8);
		pk(6, 32'(24'(CARRIER_RST[23:0] + d[23:0])));
		hb <= 1'b0;
		wt(8);
		pk(6, 32'(24'(CARRIER_RST[23:0] - d[23:0])));
		apb(OFS_RATE, 1'b1, 32'h0000_0010);
		apb(OFS_SHAPE, 1'b1, {30'h0, SHAPE_BT05});
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0001);
		gen <= 1'b1;
		e0 <= edges;
		wt(320);
		pk(3, 1);
		apb(OFS_CTRL, 1'b1, 32'h0000_0092);
		apb(OFS_PEAK, 1'b1, 32'h0000_4000);
		rssi <= 8'h80;
		wt(6);
		pk(2, 1);
		rssi <= 8'h20;
		wt(6);
		pk(2, 0);
		apb(OFS_PEAK, 1'b1, 32'h0000_1001);
		rssi <= 8'h80;
		wt(20);
		rssi <= 8'h78;
		wt(6);
		pk(2, 1);
		rssi <= 8'h70;
		wt(6);
		pk(2, 0);
		rssi <= 8'h00;
		wt(200);
		rssi <= 8'h70;
		wt(4);
		pk(2, 1);
		rssi <= 8'h00;
		wt(3000);
		rssi <= 8'h18;
		wt(6);
		pk(2, 1);
		rssi <= 8'h08;
		wt(6);
		pk(2, 0);
		// correction runs: cleared, accumulated, cleared again
		d = 32'($urandom % 4096) - 32'd2048;
		fd <= d[15:0];
		pf <= 1'b1;
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0162);
		pk(5, {27'h0, BW_RST[12:8]});
		wt(100);
		pk(5, {27'h0, BW_RST[4:0]});
		wt(1);
		pk(6, 32'(24'(CARRIER_RST[23:0] - d[23:0])));
		rd(OFS_STATUS, {13'h0, 3'b100, d[15:0]});
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0122);
		wt(100);
		pk(6, 32'(24'(CARRIER_RST[23:0] - d[23:0] - d[23:0])));
		apb(OFS_CTRL, 1'b1, 32'h0000_0000);
		apb(OFS_CTRL, 1'b1, 32'h0000_0162);
		wt(100);
		pk(6, 32'(24'(CARRIER_RST[23:0] - d[23:0])));
		// packet mode overrides the synchronizer switch
		apb(OFS_CTRL, 1'b1, 32'h0000_001A);
		e0 <= edges;
		wt(320);
		pk(3, 1);
		// one edge at the programmed rate
		dmd <= 1'b1;
		wt(12);
		pk(2, 1);
		wt(2);
		close_out();
	end
endmodule : fom_modem_tb
`default_nettype wire
